// file: hdl/shio_pkg.sv
// package: constants, register map and carrier types of the shared i/o port
package shio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PIN_W    = 16;   // pins of this port
  localparam int CN_W     = 21;   // change notice inputs
  localparam int RP_W     = 26;   // remappable pins
  localparam int SEL_W    = 5;    // selector field width
  localparam int NIN      = 8;    // remappable peripheral inputs
  localparam int IN_WORDS = 4;    // two selector fields per word
  localparam int OUT_WORDS = 13;
  localparam int NPO      = 32;   // peripheral output codes

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIR      = 8'h00;
  localparam logic [7:0] OFS_LAT      = 8'h04;
  localparam logic [7:0] OFS_LEVEL    = 8'h08;
  localparam logic [7:0] OFS_ODC      = 8'h0c;
  localparam logic [7:0] OFS_ACFG     = 8'h10;
  localparam logic [7:0] OFS_CNEN_LO  = 8'h14;
  localparam logic [7:0] OFS_CNEN_HI  = 8'h18;
  localparam logic [7:0] OFS_CNPU_LO  = 8'h1c;
  localparam logic [7:0] OFS_CNPU_HI  = 8'h20;
  localparam logic [7:0] OFS_CN_STAT  = 8'h24;
  localparam logic [7:0] OFS_OSC      = 8'h28;
  localparam logic [7:0] OFS_IN_MAP   = 8'h40;
  localparam logic [7:0] OFS_OUT_MAP  = 8'h60;

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam logic [15:0] IMPL_MASK   = 16'h7fff;  // bit 15 absent on this variant
  localparam logic [15:0] ANALOG_MASK = 16'h003f;  // pins with an analog function
  localparam logic [15:0] DIR_RST     = IMPL_MASK;
  localparam logic [15:0] ACFG_RST    = 16'h0000;
  localparam int          CN_LO_W     = 16;
  localparam int          CN_HI_W     = CN_W - CN_LO_W;
  localparam int          LOCK_BIT    = 6;
  localparam int          FLD1_POS    = 8;        // second field of a map word
  localparam logic [7:0]  UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY2 = 8'h57;
  localparam logic [4:0]  OUT_NULL    = 5'h00;
  localparam logic        LOCK_RST    = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SHIO_UNL_IDLE = 3'b001,
    SHIO_UNL_KEY1 = 3'b010,
    SHIO_UNL_OPEN = 3'b100
  } shio_unl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } shio_av_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } shio_av_rsp_t;

  typedef struct packed {
    logic [PIN_W-1:0] en;     // peripheral enabled
    logic [PIN_W-1:0] drive;  // peripheral actively driving
    logic [PIN_W-1:0] dout;   // peripheral output level
  } shio_periph_t;

  typedef struct packed {
    logic [PIN_W-1:0] out;
    logic [PIN_W-1:0] oe;
  } shio_pad_t;

  function automatic logic [31:0] shio_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : shio_merge

endpackage : shio_pkg

// file: hdl/shio_sync.sv
// two-flop synchroniser for a vector of pad inputs
`timescale 1ns/1ps
`default_nettype none

module shio_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // clock
  input  wire logic         rst_n_i, // synchronised reset, active low
  input  wire logic         ce_i,    // clock enable
  input  wire logic [W-1:0] d_i,     // asynchronous input
  output logic      [W-1:0] q_o      // synchronised output
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } shio_sync_t;

  shio_sync_t st_reg;
  shio_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;

endmodule : shio_sync

`default_nettype wire

// file: hdl/shio_port.sv
// shared i/o port with pin remapping and change notification
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module shio_port (
  input  wire logic                          clk_i,          // 20 mhz clock
  input  wire logic                          rst_n_i,        // async reset, active low
  input  wire logic                          ce_i,           // clock enable
  input  wire shio_pkg::shio_av_req_t        av_req_i,       // avalon request
  output shio_pkg::shio_av_rsp_t             av_rsp_o,       // avalon answer
  input  wire logic [shio_pkg::PIN_W-1:0]    pin_in_i,       // pad levels
  output shio_pkg::shio_pad_t                pad_o,          // pad drive and enable
  input  wire shio_pkg::shio_periph_t        periph_i,       // shared peripheral controls
  output logic      [shio_pkg::PIN_W-1:0]    periph_din_o,   // pin level to peripherals
  output logic      [shio_pkg::PIN_W-1:0]    analog_sel_o,   // 1 = pin in analog mode
  input  wire logic [shio_pkg::CN_W-1:0]     cn_pin_i,       // change notice inputs
  output logic      [shio_pkg::CN_W-1:0]     cn_pullup_o,    // weak pull-up enables
  output logic                               cn_irq_o,       // change notice request
  input  wire logic [shio_pkg::RP_W-1:0]     rp_in_i,        // remappable pad levels
  output logic      [shio_pkg::NIN-1:0]      rp_periph_in_o, // remapped peripheral inputs
  input  wire logic [shio_pkg::NPO-1:0]      rp_src_i,       // peripheral outputs by code
  output logic      [shio_pkg::RP_W-1:0]     rp_out_o,       // remapped pin level
  output logic      [shio_pkg::RP_W-1:0]     rp_taken_o,     // pin held by a peripheral
  output logic                               map_lock_o      // remap write lock state
);
  import shio_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // assertion acts at once; release is timed to this clock so no flop sees it mid-edge
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // pad input synchronisers
  // ----------------------------------------------------------------
  // pin samples trail the pads by two edges; every read and compare sees that lag
  localparam int SYNC_W = PIN_W + CN_W + RP_W;

  logic [SYNC_W-1:0] sync_q;
  logic [PIN_W-1:0]  pin_s;
  logic [CN_W-1:0]   cn_s;
  logic [RP_W-1:0]   rp_s;

  shio_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .d_i     ({rp_in_i, cn_pin_i, pin_in_i}),
    .q_o     (sync_q)
  );

  assign pin_s = sync_q[PIN_W-1:0];
  assign cn_s  = sync_q[PIN_W +: CN_W];
  assign rp_s  = sync_q[PIN_W+CN_W +: RP_W];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0]                dir;
    logic [PIN_W-1:0]                lat;
    logic [PIN_W-1:0]                odc;
    logic [PIN_W-1:0]                acfg;
    logic [CN_W-1:0]                 cn_en;
    logic [CN_W-1:0]                 cn_pu;
    logic [CN_W-1:0]                 cn_flag;
    logic [CN_W-1:0]                 cn_prev;
    logic                            cn_primed;
    logic [NIN-1:0][SEL_W-1:0]       in_map;
    logic [RP_W-1:0][SEL_W-1:0]      out_map;
    logic                            lock;
    shio_unl_t                       unl;
    logic                            ack;
    logic [31:0]                     rdata;
  } shio_state_t;

  shio_state_t st_reg;
  shio_state_t st_next;

  logic [PIN_W-1:0] level_rd;
  logic [CN_W-1:0]  cn_chg;
  logic             bus_acc;
  logic [PIN_W-1:0] analog_mode;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // every access gets one wait state so read data always leaves a flop
  assign bus_acc = av_req_i.read | av_req_i.write;

  // ----------------------------------------------------------------
  // analog mode and pin level read
  // ----------------------------------------------------------------
  // a clear configuration bit means analog; only pins with an analog function follow it
  assign analog_mode = ANALOG_MASK & ~st_reg.acfg;

  // unimplemented and analog pins read low; sampling adds latency, hence the cycle gap
  assign level_rd = pin_s & IMPL_MASK & ~analog_mode;

  // ----------------------------------------------------------------
  // map register address decode
  // ----------------------------------------------------------------
  // one hit bit per map word keeps the read and the write decode identical
  logic [IN_WORDS-1:0]  in_hit;
  logic [OUT_WORDS-1:0] out_hit;

  for (genvar j = 0; j < IN_WORDS; j++) begin : g_in_hit
    assign in_hit[j] = (av_req_i.address == 8'(OFS_IN_MAP + 8'(j * 4)));
  end

  for (genvar j = 0; j < OUT_WORDS; j++) begin : g_out_hit
    assign out_hit[j] = (av_req_i.address == 8'(OFS_OUT_MAP + 8'(j * 4)));
  end

  // ----------------------------------------------------------------
  // change notice compare, one lane per input
  // ----------------------------------------------------------------
  // the first sample only primes the compare, so leaving reset is not an event
  for (genvar c = 0; c < CN_W; c++) begin : g_cn
    logic moved;
    assign moved     = cn_s[c] ^ st_reg.cn_prev[c];
    assign cn_chg[c] = moved & st_reg.cn_en[c] & st_reg.cn_primed;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        acc;
    logic        do_wr;
    logic [31:0] rd;
    logic [31:0] wm;
    logic [CN_W-1:0] clr;
    st_next = st_reg;
    acc     = bus_acc;
    do_wr   = av_req_i.write & st_reg.ack;
    rd      = '0;
    wm      = '0;
    clr     = '0;

    // read decode; unmapped offsets read zero
    unique case (av_req_i.address)
      OFS_DIR:     rd[PIN_W-1:0] = st_reg.dir & IMPL_MASK;
      OFS_LAT:     rd[PIN_W-1:0] = st_reg.lat & IMPL_MASK;
      OFS_LEVEL:   rd[PIN_W-1:0] = level_rd;
      OFS_ODC:     rd[PIN_W-1:0] = st_reg.odc;
      OFS_ACFG:    rd[PIN_W-1:0] = st_reg.acfg;
      OFS_CNEN_LO: rd[CN_LO_W-1:0] = st_reg.cn_en[CN_LO_W-1:0];
      OFS_CNEN_HI: rd[CN_HI_W-1:0] = st_reg.cn_en[CN_W-1:CN_LO_W];
      OFS_CNPU_LO: rd[CN_LO_W-1:0] = st_reg.cn_pu[CN_LO_W-1:0];
      OFS_CNPU_HI: rd[CN_HI_W-1:0] = st_reg.cn_pu[CN_W-1:CN_LO_W];
      OFS_CN_STAT: rd[CN_W-1:0] = st_reg.cn_flag;
      OFS_OSC:     rd[LOCK_BIT] = st_reg.lock;
      default: begin
        for (int j = 0; j < IN_WORDS; j++) begin
          if (in_hit[j]) begin
            rd[SEL_W-1:0]            = st_reg.in_map[2*j];
            rd[FLD1_POS +: SEL_W]    = st_reg.in_map[2*j+1];
          end
        end
        for (int j = 0; j < OUT_WORDS; j++) begin
          if (out_hit[j]) begin
            rd[SEL_W-1:0]            = st_reg.out_map[2*j];
            rd[FLD1_POS +: SEL_W]    = st_reg.out_map[2*j+1];
          end
        end
      end
    endcase

    // one wait state: data is captured now and presented with waitrequest low
    st_next.ack = acc & ~st_reg.ack;
    if (acc && !st_reg.ack) begin
      st_next.rdata = rd;
    end

    wm = shio_merge(rd, av_req_i.writedata, av_req_i.byteenable);
    if (do_wr) begin
      unique case (av_req_i.address)
        OFS_DIR:     st_next.dir = wm[PIN_W-1:0] & IMPL_MASK;
        OFS_LAT:     st_next.lat = wm[PIN_W-1:0] & IMPL_MASK;
        OFS_LEVEL: begin
          // merge into the latch, not into the sampled pins that the read path shows
          wm          = shio_merge({16'h0000, st_reg.lat}, av_req_i.writedata, av_req_i.byteenable);
          st_next.lat = wm[PIN_W-1:0] & IMPL_MASK;
        end
        OFS_ODC:     st_next.odc = wm[PIN_W-1:0] & IMPL_MASK;
        OFS_ACFG:    st_next.acfg = wm[PIN_W-1:0];
        OFS_CNEN_LO: st_next.cn_en[CN_LO_W-1:0] = wm[CN_LO_W-1:0];
        OFS_CNEN_HI: st_next.cn_en[CN_W-1:CN_LO_W] = wm[CN_HI_W-1:0];
        OFS_CNPU_LO: st_next.cn_pu[CN_LO_W-1:0] = wm[CN_LO_W-1:0];
        OFS_CNPU_HI: st_next.cn_pu[CN_W-1:CN_LO_W] = wm[CN_HI_W-1:0];
        OFS_CN_STAT: begin
          // write one to clear; the clear acts on every lane, enabled or not
          wm  = shio_merge(32'h0000_0000, av_req_i.writedata, av_req_i.byteenable);
          clr = wm[CN_W-1:0];
        end
        OFS_OSC: begin
          // lock bit moves only on the write that follows both keys
          if (!av_req_i.byteenable[0]) begin
            st_next.unl = SHIO_UNL_IDLE;
          end else begin
            unique case (st_reg.unl)
              SHIO_UNL_OPEN: begin
                st_next.lock = av_req_i.writedata[LOCK_BIT];
                st_next.unl  = SHIO_UNL_IDLE;
              end
              SHIO_UNL_KEY1: begin
                st_next.unl = (av_req_i.writedata[7:0] == UNLOCK_KEY2) ? SHIO_UNL_OPEN :
                              (av_req_i.writedata[7:0] == UNLOCK_KEY1) ? SHIO_UNL_KEY1 :
                              SHIO_UNL_IDLE;
              end
              SHIO_UNL_IDLE: begin
                st_next.unl = (av_req_i.writedata[7:0] == UNLOCK_KEY1) ? SHIO_UNL_KEY1 :
                              SHIO_UNL_IDLE;
              end
              default: st_next.unl = SHIO_UNL_IDLE;
            endcase
          end
        end
        default: begin
          // map registers silently keep their value while locked
          if (!st_reg.lock) begin
            for (int j = 0; j < IN_WORDS; j++) begin
              if (in_hit[j]) begin
                st_next.in_map[2*j]   = wm[SEL_W-1:0];
                st_next.in_map[2*j+1] = wm[FLD1_POS +: SEL_W];
              end
            end
            for (int j = 0; j < OUT_WORDS; j++) begin
              if (out_hit[j]) begin
                st_next.out_map[2*j]   = wm[SEL_W-1:0];
                st_next.out_map[2*j+1] = wm[FLD1_POS +: SEL_W];
              end
            end
          end
        end
      endcase
    end

    // change notice: a change in the cycle of a clear keeps its flag
    st_next.cn_prev   = cn_s;
    st_next.cn_primed = 1'b1;
    st_next.cn_flag   = (st_reg.cn_flag & ~clr) | cn_chg;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.dir     <= DIR_RST;
      st_reg.acfg    <= ACFG_RST;
      st_reg.lock    <= LOCK_RST;
      st_reg.unl     <= SHIO_UNL_IDLE;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // pin ownership and pad drive
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    logic owned;
    logic port_drv;
    logic data;
    logic drv;
    assign owned    = periph_i.en[i] & periph_i.drive[i];
    assign port_drv = ~st_reg.dir[i] & ~owned;
    assign data     = owned ? periph_i.dout[i] : st_reg.lat[i];
    assign drv      = (owned | port_drv) & IMPL_MASK[i];
    // open drain: pull low only, release for a high level
    assign pad_o.out[i] = data & ~st_reg.odc[i];
    assign pad_o.oe[i]  = drv & ~(st_reg.odc[i] & data);
    // peripheral never sees the port's own output
    assign periph_din_o[i] = pin_s[i] & ~port_drv;
  end

  // ----------------------------------------------------------------
  // remap: inputs by peripheral, outputs by pin
  // ----------------------------------------------------------------
  for (genvar k = 0; k < NIN; k++) begin : g_in_map
    // direction is left alone: a mapped input pin needs its direction bit set
    // out-of-range selector routes a low level
    assign rp_periph_in_o[k] = (int'(st_reg.in_map[k]) < RP_W) ?
                               rp_s[st_reg.in_map[k]] : 1'b0;
  end

  for (genvar n = 0; n < RP_W; n++) begin : g_out_map
    assign rp_taken_o[n] = (st_reg.out_map[n] != OUT_NULL);
    assign rp_out_o[n]   = rp_taken_o[n] & rp_src_i[st_reg.out_map[n]];
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign av_rsp_o.waitrequest = bus_acc & ~st_reg.ack;
  assign av_rsp_o.readdata    = st_reg.rdata;
  assign analog_sel_o         = analog_mode;
  assign cn_pullup_o          = st_reg.cn_pu;
  assign cn_irq_o             = |st_reg.cn_flag;
  assign map_lock_o           = st_reg.lock;

endmodule : shio_port

`default_nettype wire

// file: verification/shio_port_checker.sv
// checker: port-level properties of the shared i/o port
`timescale 1ns/1ps
`default_nettype none
module shio_port_checker (
  input wire logic                   clk_i,        // clock
  input wire logic                   rst_n_i,      // reset, active low
  input wire shio_pkg::shio_av_req_t av_req_i,     // bus request
  input wire shio_pkg::shio_av_rsp_t av_rsp_o,     // bus answer
  input wire shio_pkg::shio_pad_t    pad_o,        // pad drive
  input wire shio_pkg::shio_periph_t periph_i,     // peripheral controls
  input wire logic [15:0]            periph_din_o, // level to peripherals
  input wire logic [15:0]            analog_sel_o, // analog mode
  input wire logic [20:0]            cn_pin_i,     // change inputs
  input wire logic                   cn_irq_o,     // change request
  input wire logic                   map_lock_o    // map lock
);
  import shio_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] own;
  logic        tk;
  assign own = periph_i.en & periph_i.drive;
  assign tk  = !av_rsp_o.waitrequest;
  sequence s_ans;
    av_rsp_o.waitrequest ##1 !av_rsp_o.waitrequest;
  endsequence
  property p_ans;
    $rose(av_req_i.read | av_req_i.write) |-> s_ans;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer not after one wait state");
  property p_own;
    own != 16'h0 |-> (pad_o.oe & own & ~periph_i.dout) == (own & ~periph_i.dout)
      && (pad_o.out & own) == (pad_o.oe & own & periph_i.dout);
  endproperty
  a_own: assert property (p_own) else $error("peripheral lost its pin");
  property p_loop;
    (pad_o.oe & ~own & periph_din_o) == 16'h0;
  endproperty
  a_loop: assert property (p_loop) else $error("port output looped to peripheral");
  property p_b15;
    !own[15] |-> !pad_o.oe[15];
  endproperty
  a_b15: assert property (p_b15) else $error("absent pin driven");
  property p_rd15;
    av_req_i.read && tk && av_req_i.address <= OFS_LEVEL |-> av_rsp_o.readdata[31:15] == 17'h0;
  endproperty
  a_rd15: assert property (p_rd15) else $error("absent bit read nonzero");
  property p_rst;
    $rose(rst_n_i) |-> ##3 analog_sel_o == ANALOG_MASK && !map_lock_o && !cn_irq_o && (pad_o.oe & ~own) == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("wrong state after reset");
  property p_lock;
    $changed(map_lock_o) |-> $past(av_req_i.write && tk && av_req_i.address == OFS_OSC);
  endproperty
  a_lock: assert property (p_lock) else $error("lock moved without a write");
  property p_cn;
    $rose(cn_irq_o) |-> $past(cn_pin_i, 2) != $past(cn_pin_i, 3) || $past(cn_pin_i, 3) != $past(cn_pin_i, 4)
      || $past(cn_pin_i, 4) != $past(cn_pin_i, 5);
  endproperty
  a_cn: assert property (p_cn) else $error("change request without a change");
  property p_fall;
    $fell(cn_irq_o) |-> $past(av_req_i.write && tk && av_req_i.address == OFS_CN_STAT);
  endproperty
  a_fall: assert property (p_fall) else $error("change flag dropped by itself");
endmodule : shio_port_checker
bind shio_port shio_port_checker shio_port_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .av_req_i(av_req_i),
  .av_rsp_o(av_rsp_o), .pad_o(pad_o), .periph_i(periph_i), .periph_din_o(periph_din_o),
  .analog_sel_o(analog_sel_o), .cn_pin_i(cn_pin_i), .cn_irq_o(cn_irq_o), .map_lock_o(map_lock_o));
`default_nettype wire

// file: verification/shio_pins.sv
// partner: pad wire resolution between the port and external drivers
`timescale 1ns/1ps
`default_nettype none
module shio_pins (
  input  wire shio_pkg::shio_pad_t        pad_i, // port pad drive
  input  wire logic [shio_pkg::PIN_W-1:0] ext_i, // external level
  output logic      [shio_pkg::PIN_W-1:0] pin_o  // resolved level
);
  import shio_pkg::*;
  // a released pin shows the outside driver, never the last port value
  assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_i);
endmodule : shio_pins
`default_nettype wire

// file: verification/shio_port_tb.sv
// testbench: bus tasks and scenarios for the shared i/o port
`timescale 1ns/1ps
`default_nettype none
module shio_port_tb;
  import shio_pkg::*;
  logic         clk_i = 0, rst_n_i = 0, ce_i = 1, irq, lock;
  shio_av_req_t req = '0;
  shio_av_rsp_t rsp;
  shio_pad_t    pad;
  shio_periph_t per = '0;
  logic [15:0]  ext = 16'hffff, pin, din, asel;
  logic [20:0]  cn = '0, pu;
  logic [25:0]  rp = '0, rpo, rpt;
  logic [7:0]   rpi;
  logic [31:0]  src = '0, q;
  int           fails = 0, samples_checked = 0;
  always #25 clk_i = ~clk_i;
  shio_pins shio_pins_i (.pad_i(pad), .ext_i(ext), .pin_o(pin));
  shio_port shio_port_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .av_req_i(req), .av_rsp_o(rsp),
    .pin_in_i(pin), .pad_o(pad), .periph_i(per), .periph_din_o(din), .analog_sel_o(asel), .cn_pin_i(cn),
    .cn_pullup_o(pu), .cn_irq_o(irq), .rp_in_i(rp), .rp_periph_in_o(rpi), .rp_src_i(src), .rp_out_o(rpo),
    .rp_taken_o(rpt), .map_lock_o(lock));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // request held until waitrequest seen low, released on the taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(negedge clk_i);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    if (rsp.waitrequest !== 1'b0) begin
      fails++;
      give_verdict();
    end
    @(posedge clk_i);
    q = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic waitirq(input logic e);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'(irq), 32'(e));
  endtask : waitirq
  task automatic pos();
    @(posedge clk_i);
  endtask : pos
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc(OFS_DIR, 32'h7fff);
    rdc(OFS_ACFG, 32'h0);
    rdc(8'hfc, 32'h0);
    wr(OFS_LAT, 32'hffff);
    rdc(OFS_LAT, 32'h7fff);
    wr(OFS_LEVEL, 32'h00a5);
    rdc(OFS_LAT, 32'h00a5);
    $display("test latch done");
    wr(OFS_DIR, 32'h0);
    @(negedge clk_i);
    chk(32'(pad.oe), 32'h7fff);
    chk(32'(pad.out & 16'h7fff), 32'h00a5);
    wr(OFS_ODC, 32'h00ff);
    @(negedge clk_i);
    chk(32'(pad.oe), 32'h7f5a);
    chk(32'(pad.out & 16'h00ff), 32'h0);
    chk(32'(din & 16'h0001), 32'h0);
    pos();
    per <= '{en: 16'h0300, drive: 16'h0100, dout: 16'h0100};
    @(negedge clk_i);
    chk(32'(pad.oe & 16'h0300), 32'h300);
    chk(32'(pad.out & 16'h0300), 32'h100);
    settle();
    chk(32'(din & 16'h0300), 32'h100);
    pos();
    per <= '0;
    $display("test pad done");
    wr(OFS_DIR, 32'hffff);
    settle();
    rdc(OFS_LEVEL, 32'h7fc0);
    wr(OFS_ACFG, 32'h003f);
    rdc(OFS_LEVEL, 32'h7fff);
    chk(32'(asel), 32'h0);
    $display("test level done");
    wr(OFS_CNPU_LO, 32'h1);
    @(negedge clk_i);
    chk(32'(pu), 32'h1);
    wr(OFS_CNEN_LO, 32'h1);
    cn <= 21'h000001;
    waitirq(1'b1);
    rdc(OFS_CN_STAT, 32'h1);
    wr(OFS_CN_STAT, 32'h1);
    @(negedge clk_i);
    chk(32'(irq), 32'h0);
    pos();
    cn <= 21'h100001;
    waitirq(1'b0);
    wr(OFS_CNEN_HI, 32'h10);
    cn <= 21'h000001;
    waitirq(1'b1);
    rdc(OFS_CN_STAT, 32'h100000);
    $display("test change done");
    wr(OFS_IN_MAP, 32'h1903);
    rp <= 26'h0000008;
    settle();
    chk(32'(rpi & 8'h03), 32'h1);
    pos();
    rp <= 26'h2000000;
    settle();
    chk(32'(rpi & 8'h03), 32'h2);
    wr(OFS_IN_MAP, 32'h1a03);
    rp <= 26'h3ffffff;
    settle();
    chk(32'(rpi & 8'h03), 32'h1);
    wr(OFS_OUT_MAP, 32'h3);
    src <= 32'h8;
    @(negedge clk_i);
    chk(32'(rpt & 26'h3), 32'h1);
    chk(32'(rpo & 26'h1), 32'h1);
    wr(OFS_OSC, 32'h46);
    wr(OFS_OSC, 32'h57);
    wr(OFS_OSC, 32'h40);
    @(negedge clk_i);
    chk(32'(lock), 32'h1);
    wr(OFS_IN_MAP, 32'h0);
    rdc(OFS_IN_MAP, 32'h1a03);
    $display("test remap done");
    wr(OFS_CN_STAT, 32'h100000);
    pos();
    ce_i <= 1'b0;
    cn <= 21'h100001;
    repeat (4) pos();
    cn <= 21'h000001;
    pos();
    ce_i <= 1'b1;
    waitirq(1'b0);
    $display("test enable done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
endmodule : shio_port_tb
`default_nettype wire
